// ### shared/rst_seq_pkg.sv
// constants, encodings and register map of the reset and time-out sequencer
package rst_seq_pkg;
  // clocking and time-out figures
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned LFOSC_HZ = 31_000;
  localparam int unsigned POWER_UP_TIMER_MS = 64;
  // low-frequency tick period in system cycles, rounded down
  localparam int unsigned LF_DIV_CYCLES = CLK_HZ / LFOSC_HZ;
  // power-up delay expressed in low-frequency ticks
  localparam int unsigned POWER_UP_TIMER_LF_TICKS = (POWER_UP_TIMER_MS * LFOSC_HZ) / 1000;
  // oscillator start-up wait in main oscillator periods
  localparam int unsigned OST_OSC_CYCLES = 1024;
  localparam int CNT_W = 16;
  localparam int OST_W = 11;

  // register bus geometry: byte address, one word per register index
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_CORE_STATUS = 8'h03;
  localparam logic [IDX_W-1:0] IDX_POWER_CONTROL = 8'h8E;

  // core status field positions
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  // power control field positions
  localparam int PC_ULTRA_LOW_POWER_WAKE_ENABLE = 5;
  localparam int PC_SOFT_BROWNOUT_ENABLE = 4;
  localparam int PC_POR = 1;
  localparam int PC_BOD = 0;

  // reset values
  localparam logic ULTRA_LOW_POWER_WAKE_ENABLE_RST = 1'b0;
  localparam logic SOFT_BROWNOUT_ENABLE_PWR_RST = 1'b1;
  localparam logic BOD_FLAG_RST = 1'b1;
  localparam logic [2:0] ST_UPPER_RST = 3'h0;
  localparam logic [2:0] ST_LOWER_RST = 3'h0;

  // brown-out detector modes
  typedef enum logic [1:0] {
    BOD_OFF = 2'b00,
    BOD_SOFT = 2'b01,
    BOD_SLEEP_GATED = 2'b10,
    BOD_ALWAYS = 2'b11
  } bod_mode_t;

  // sequencer states, gray along hold, power-up, start-up, run, sleep
  typedef enum logic [2:0] {
    S_HOLD = 3'b000,
    S_POWER_UP_TIMER = 3'b001,
    S_OST = 3'b011,
    S_RUN = 3'b010,
    S_SLEEP = 3'b110
  } seq_state_t;
endpackage

// ### logic/reset_timeout_sequencer.sv
// reset sequencing, brown-out gating and reset cause flags with an avalon slave
//
// Function
// - 64 ms power-up delay after power-on/brown-out only
// - power-up delay counts low-frequency oscillator ticks
// - chip held in reset while delay runs
// - active-low enable bit turns delay on/off
// - mode field; mode 01 uses software enable
// - sleep-gated mode: detector off in sleep
// - long supply dip below threshold resets chip
// - wait for supply, then optional 64 ms
// - brown-out during delay restarts it fully
// - start-up wait after power-up delay, or alone with delay off or on wake
// - crystal modes wait 1024 oscillator periods
// - other clock modes skip start-up wait
// - two-speed/fail-safe: run internal clock during wait
// - pin low past time-outs, release runs at once
// - brown-out clears flag bit 0; software sets
// - power-on clears flag bit 1; software sets
// - cause flags follow the reset type table
// - power and other resets load distinct values
// - power control map; unused bits read zero
// - watchdog reset never drives the reset pin
`timescale 1ns/1ps
module reset_timeout_sequencer #(
  parameter int unsigned LF_DIV = rst_seq_pkg::LF_DIV_CYCLES,
  parameter int unsigned POWER_UP_TIMER_TICKS = rst_seq_pkg::POWER_UP_TIMER_LF_TICKS,
  parameter int unsigned OST_CYCLES = rst_seq_pkg::OST_OSC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration word
  input wire logic power_up_timer_enable_n,
  input wire rst_seq_pkg::bod_mode_t brownout_mode_select,
  input wire logic osc_crystal,
  input wire logic two_speed_en,
  input wire logic fail_safe_en,
  // analog monitors and pin
  input wire logic por_active,
  input wire logic vdd_above_bod,
  input wire logic bod_trip,
  input wire logic external_reset_pin_n,
  // core and clock events
  input wire logic osc_tick,
  input wire logic wdt_reset,
  input wire logic wdt_wake,
  input wire logic irq_wake,
  input wire logic sleep_entry,
  input wire logic wdt_clear,
  // avalon-mm slave
  input wire logic [rst_seq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // towards core, clocks and analog
  output logic chip_reset,
  output logic internal_oscillator_exec,
  output logic ost_running,
  output logic bod_enable,
  output logic reset_pin_oe
);
  import rst_seq_pkg::*;

  seq_state_t state_q, state_d;
  logic [CNT_W-1:0] lf_div_q, lf_div_d;
  logic [CNT_W-1:0] power_up_timer_cnt_q, power_up_timer_cnt_d;
  logic [OST_W-1:0] ost_cnt_q, ost_cnt_d;
  logic power_up_q, power_up_d;
  logic external_reset_pin_n_prev_q;
  logic ultra_low_power_wake_enable_q, ultra_low_power_wake_enable_d;
  logic soft_brownout_enable_q, soft_brownout_enable_d;
  logic por_n_q, por_n_d;
  logic bod_n_q, bod_n_d;
  logic to_n_q, to_n_d;
  logic pd_n_q, pd_n_d;
  logic [2:0] st_upper_q, st_upper_d;
  logic [2:0] st_lower_q, st_lower_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic chip_reset_q, internal_oscillator_exec_q, ost_running_q, bod_enable_q, pin_oe_q;

  // detector enable per mode; off mode never trips
  wire soft_mode = (brownout_mode_select == BOD_SOFT);
  wire gated_mode = (brownout_mode_select == BOD_SLEEP_GATED);
  wire always_mode = (brownout_mode_select == BOD_ALWAYS);
  wire bod_en = always_mode
    | (soft_mode & soft_brownout_enable_q)
    | (gated_mode & (state_q != S_SLEEP));
  // the analog side already filters dips shorter than the minimum duration
  wire bod_hit = bod_trip & bod_en;

  // low-frequency time base; a divider because there is only one clock
  wire lf_tick = (lf_div_q == CNT_W'(LF_DIV - 1));
  wire power_up_timer_done = (power_up_timer_cnt_q == CNT_W'(POWER_UP_TIMER_TICKS));
  wire ost_done = (ost_cnt_q == OST_W'(OST_CYCLES));
  wire power_up_timer_on = ~power_up_timer_enable_n;
  wire fast_start = two_speed_en | fail_safe_en;

  // reset pin events, pin taken as synchronous
  wire external_reset_pin_n_fall = external_reset_pin_n_prev_q & ~external_reset_pin_n;
  wire external_reset_pin_n_low = ~external_reset_pin_n;
  wire hold_exit = ~por_active & vdd_above_bod & ~bod_hit;
  wire power_evt = por_active | bod_hit;
  wire other_rst = wdt_reset | (external_reset_pin_n_fall & (state_q == S_RUN));

  // bus decode; one wait state, answer on the following edge
  wire [IDX_W-1:0] reg_idx = address[ADDR_W-1:2];
  wire hit_status = (reg_idx == IDX_CORE_STATUS);
  wire hit_power_control_flags = (reg_idx == IDX_POWER_CONTROL);
  wire bus_done = (read | write) & ~wait_q;
  wire wr_status = write & bus_done & hit_status;
  wire wr_power_control_flags = write & bus_done & hit_power_control_flags;
  wire [7:0] status_rd = {st_upper_q, to_n_q, pd_n_q, st_lower_q};
  // only four bits of power control are implemented, others read zero
  wire [7:0] power_control_flags_rd = {2'b00, ultra_low_power_wake_enable_q, soft_brownout_enable_q, 2'b00, por_n_q, bod_n_q};
  wire [7:0] rd_sel = hit_status ? status_rd : (hit_power_control_flags ? power_control_flags_rd : 8'h00);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    power_up_d = power_up_q;
    power_up_timer_cnt_d = power_up_timer_cnt_q;
    ost_cnt_d = ost_cnt_q;
    if (power_evt) begin
      // brown-out or power-on restarts the full sequence
      state_d = S_HOLD;
      power_up_d = 1'b1;
      power_up_timer_cnt_d = '0;
      ost_cnt_d = '0;
    end else if (wdt_reset) begin
      // internal reset only, no power-up delay afterwards
      state_d = S_HOLD;
      power_up_d = 1'b0;
    end else begin
      case (state_q)
        S_HOLD: begin
          if (hold_exit) begin
            power_up_timer_cnt_d = '0;
            ost_cnt_d = '0;
            if (power_up_q && power_up_timer_on) begin
              state_d = S_POWER_UP_TIMER;
            end else if (power_up_q && osc_crystal) begin
              state_d = S_OST;
            end else begin
              // non-crystal modes with the delay disabled have no time-out
              state_d = S_RUN;
            end
          end
        end
        S_POWER_UP_TIMER: begin
          if (!vdd_above_bod) begin
            state_d = S_HOLD;
            power_up_timer_cnt_d = '0;
          end else if (power_up_timer_done) begin
            // start-up wait strictly follows the power-up delay
            state_d = osc_crystal ? S_OST : S_RUN;
          end else if (lf_tick) begin
            power_up_timer_cnt_d = power_up_timer_cnt_q + CNT_W'(1);
          end
        end
        S_OST: begin
          if (ost_done) begin
            state_d = S_RUN;
            power_up_d = 1'b0;
          end else if (osc_tick) begin
            ost_cnt_d = ost_cnt_q + OST_W'(1);
          end
        end
        S_RUN: begin
          power_up_d = 1'b0;
          if (sleep_entry) begin
            state_d = S_SLEEP;
          end
        end
        S_SLEEP: begin
          if (external_reset_pin_n_fall) begin
            state_d = S_RUN;
          end else if (irq_wake || wdt_wake) begin
            ost_cnt_d = '0;
            state_d = osc_crystal ? S_OST : S_RUN;
          end
        end
        default: begin
          state_d = S_HOLD;
        end
      endcase
    end
  end

  // divider restarts with each power-up delay so the first tick is a full one
  always_comb begin
    if (lf_tick || state_q != S_POWER_UP_TIMER) begin
      lf_div_d = '0;
    end else begin
      lf_div_d = lf_div_q + CNT_W'(1);
    end
  end

  // power control flags; hardware events win over a software write
  always_comb begin
    ultra_low_power_wake_enable_d = ultra_low_power_wake_enable_q;
    soft_brownout_enable_d = soft_brownout_enable_q;
    por_n_d = por_n_q;
    bod_n_d = bod_n_q;
    if (wr_power_control_flags) begin
      ultra_low_power_wake_enable_d = writedata[PC_ULTRA_LOW_POWER_WAKE_ENABLE];
      soft_brownout_enable_d = writedata[PC_SOFT_BROWNOUT_ENABLE];
      por_n_d = writedata[PC_POR];
      bod_n_d = writedata[PC_BOD];
    end
    if (power_evt) begin
      ultra_low_power_wake_enable_d = ULTRA_LOW_POWER_WAKE_ENABLE_RST;
      soft_brownout_enable_d = SOFT_BROWNOUT_ENABLE_PWR_RST;
    end else if (other_rst) begin
      ultra_low_power_wake_enable_d = ULTRA_LOW_POWER_WAKE_ENABLE_RST;
    end
    if (por_active) begin
      por_n_d = 1'b0;
    end
    if (bod_hit) begin
      bod_n_d = 1'b0;
    end
  end

  // core status; timeout and powerdown flags are read-only to software
  always_comb begin
    st_upper_d = st_upper_q;
    st_lower_d = st_lower_q;
    to_n_d = to_n_q;
    pd_n_d = pd_n_q;
    if (wr_status) begin
      st_upper_d = writedata[7:5];
      st_lower_d = writedata[2:0];
    end
    if (sleep_entry && state_q == S_RUN) begin
      to_n_d = 1'b1;
      pd_n_d = 1'b0;
    end
    if (wdt_clear) begin
      to_n_d = 1'b1;
      pd_n_d = 1'b1;
    end
    if (power_evt) begin
      st_upper_d = ST_UPPER_RST;
      to_n_d = 1'b1;
      pd_n_d = 1'b1;
    end else if (wdt_wake && state_q == S_SLEEP) begin
      to_n_d = 1'b0;
      pd_n_d = 1'b0;
    end else if (wdt_reset) begin
      st_upper_d = ST_UPPER_RST;
      to_n_d = 1'b0;
    end else if (external_reset_pin_n_fall && state_q == S_SLEEP) begin
      st_upper_d = ST_UPPER_RST;
      to_n_d = 1'b1;
      pd_n_d = 1'b0;
    end else if (external_reset_pin_n_fall) begin
      st_upper_d = ST_UPPER_RST;
    end
  end

  // time-outs run regardless of the pin; the pin only adds its own hold
  wire seq_hold = (state_q == S_HOLD) | (state_q == S_POWER_UP_TIMER)
    | ((state_q == S_OST) & ~fast_start);
  wire chip_reset_d = seq_hold | external_reset_pin_n_low | wdt_reset;
  wire internal_oscillator_exec_d = (state_q == S_OST) & fast_start;

  // sequencer and counters
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_HOLD;
      power_up_q <= 1'b1;
      power_up_timer_cnt_q <= '0;
      ost_cnt_q <= '0;
      lf_div_q <= '0;
      external_reset_pin_n_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      power_up_q <= power_up_d;
      power_up_timer_cnt_q <= power_up_timer_cnt_d;
      ost_cnt_q <= ost_cnt_d;
      lf_div_q <= lf_div_d;
      external_reset_pin_n_prev_q <= external_reset_pin_n;
    end
  end

  // software-visible flags; design reset behaves as a power-on
  always_ff @(posedge clk) begin
    if (rst) begin
      ultra_low_power_wake_enable_q <= ULTRA_LOW_POWER_WAKE_ENABLE_RST;
      soft_brownout_enable_q <= SOFT_BROWNOUT_ENABLE_PWR_RST;
      por_n_q <= 1'b0;
      bod_n_q <= BOD_FLAG_RST;
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
      st_upper_q <= ST_UPPER_RST;
      st_lower_q <= ST_LOWER_RST;
    end else begin
      ultra_low_power_wake_enable_q <= ultra_low_power_wake_enable_d;
      soft_brownout_enable_q <= soft_brownout_enable_d;
      por_n_q <= por_n_d;
      bod_n_q <= bod_n_d;
      to_n_q <= to_n_d;
      pd_n_q <= pd_n_d;
      st_upper_q <= st_upper_d;
      st_lower_q <= st_lower_d;
    end
  end

  // bus answer: waitrequest drops one cycle after the request appears
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~((read | write) & wait_q);
      rdata_q <= {24'h00_0000, rd_sel};
    end
  end

  // registered outputs; the pin driver stays off, watchdog resets stay inside
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_reset_q <= 1'b1;
      internal_oscillator_exec_q <= 1'b0;
      ost_running_q <= 1'b0;
      bod_enable_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      chip_reset_q <= chip_reset_d;
      internal_oscillator_exec_q <= internal_oscillator_exec_d;
      ost_running_q <= (state_q == S_OST);
      bod_enable_q <= bod_en;
      pin_oe_q <= 1'b0;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign chip_reset = chip_reset_q;
  assign internal_oscillator_exec = internal_oscillator_exec_q;
  assign ost_running = ost_running_q;
  assign bod_enable = bod_enable_q;
  assign reset_pin_oe = pin_oe_q;

  // checks on the sequencer, flags and bus
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_power_up_timer_holds_reset: assert property (
    (state_q == S_POWER_UP_TIMER) |=> chip_reset_q)
    else $error("chip left reset during power-up delay");
  a_power_up_timer_enable_bit: assert property (
    (state_q == S_HOLD && hold_exit && !power_evt && !wdt_reset
      && power_up_timer_enable_n) |=> (state_q != S_POWER_UP_TIMER))
    else $error("power-up delay ran while disabled");
  a_soft_bod_mode: assert property (
    (soft_mode && !wr_power_control_flags && !power_evt) |=> (bod_enable_q == $past(soft_brownout_enable_q)))
    else $error("software brown-out enable not followed");
  a_sleep_gated_off: assert property (
    (gated_mode && state_q == S_SLEEP) |=> !bod_enable_q)
    else $error("detector left on during sleep");
  a_bod_always_on: assert property (
    always_mode |=> bod_enable_q)
    else $error("detector off in always mode");
  a_bod_restarts: assert property (
    (state_q == S_POWER_UP_TIMER && (bod_hit || !vdd_above_bod) && !wdt_reset)
      |=> (state_q == S_HOLD && power_up_timer_cnt_q == '0))
    else $error("brown-out did not restart power-up delay");
  a_ost_follows: assert property (
    (state_q == S_POWER_UP_TIMER && power_up_timer_done && osc_crystal && vdd_above_bod
      && !power_evt && !wdt_reset) |=> (state_q == S_OST) ##1 ost_running_q)
    else $error("start-up wait did not follow power-up delay");
  a_no_ost_rc: assert property (
    (state_q != S_OST && !osc_crystal) |=> (state_q != S_OST))
    else $error("start-up wait in non-crystal mode");
  a_fast_start: assert property (
    (state_q == S_OST && fast_start && external_reset_pin_n && !wdt_reset)
      |=> (internal_oscillator_exec_q && !chip_reset_q))
    else $error("core not released on internal clock");
  a_pin_release: assert property (
    (state_q == S_RUN && external_reset_pin_n && !$past(external_reset_pin_n)
      && !wdt_reset) |=> !chip_reset_q)
    else $error("pin release did not start execution");
  a_flags_clear: assert property (
    bod_hit |=> !bod_n_q)
    else $error("brown-out flag not cleared");
  a_por_flag: assert property (
    por_active |=> (!por_n_q && power_control_flags_rd[PC_SOFT_BROWNOUT_ENABLE] && to_n_q && pd_n_q))
    else $error("power-on flags wrong");
  a_wdt_pin_quiet: assert property (
    wdt_reset |=> (chip_reset_q && !reset_pin_oe) ##1 !reset_pin_oe)
    else $error("watchdog reset drove the pin");
  a_bus_answer: assert property (
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus answer late");

  c_full_sequence: cover property ((state_q == S_POWER_UP_TIMER) ##1 (state_q == S_OST));
  c_wdt_wake: cover property ((state_q == S_SLEEP) ##1 wdt_wake);
  c_bod_restart: cover property ((state_q == S_POWER_UP_TIMER) && !vdd_above_bod);
  c_pin_late: cover property ((state_q == S_RUN) && external_reset_pin_n_low ##1 external_reset_pin_n);
endmodule // reset_timeout_sequencer

// ### tb/supply_clock_model.sv
// supply monitor and main oscillator model facing the reset sequencer
`timescale 1ns/1ps
module supply_clock_model #(
  parameter int TICK_GAP = 2,
  parameter int FILTER = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // supply dip asked for by the bench
  input wire logic dip,
  // towards the sequencer
  output logic osc_tick,
  output logic vdd_above_bod,
  output logic bod_trip
);
  int gap_q;
  int low_q;
  // oscillator period tick; a crystal runs free, so it never stops
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q <= 0;
    end else begin
      gap_q <= (gap_q + 1) % TICK_GAP;
    end
  end
  assign osc_tick = (gap_q == 0);
  // dips shorter than the filter never reach the trip line
  always_ff @(posedge clk) begin
    if (!dip) begin
      low_q <= 0;
    end else if (low_q < FILTER) begin
      low_q <= low_q + 1;
    end
  end
  assign vdd_above_bod = !dip;
  assign bod_trip = (low_q >= FILTER);
endmodule // supply_clock_model

// ### tb/reset_timeout_sequencer_test.sv
// power-up, start-up, brown-out and reset cause tests of the reset sequencer
`timescale 1ns/1ps
module reset_timeout_sequencer_test;
  import rst_seq_pkg::*;
  localparam int LF = 4;
  localparam int TK = 5;
  localparam int OSTC = 8;
  localparam int DLY = LF * TK;
  localparam logic [9:0] A_ST = 10'h00C;
  localparam logic [9:0] A_PC = 10'h238;
  logic clk, rst, power_up_timer_enable_n_n, xtal, two_speed, fail_safe, por, dip, pin_n;
  logic wdt_rst, wdt_wk, irq_wk, slp, wdt_clr, read, write;
  bod_mode_t mode;
  logic [9:0] address;
  logic [31:0] writedata, readdata, q;
  logic waitrequest, chip_reset, internal_oscillator_exec, ost_running, bod_enable, reset_pin_oe;
  logic osc_tick, vdd_ok, bod_trip, seen_ost, seen_int;
  int err_total, samples_checked, n, m;
  int lo[6] = '{DLY, DLY + 2 * OSTC - 2, DLY, 0, 2 * OSTC - 2, DLY};
  int hi[6] = '{DLY + 6, DLY + 2 * OSTC + 8, DLY + 6, 4, 2 * OSTC + 8, DLY + 6};

  reset_timeout_sequencer #(.LF_DIV(LF), .POWER_UP_TIMER_TICKS(TK), .OST_CYCLES(OSTC)) u_dut (
    .clk(clk), .rst(rst), .power_up_timer_enable_n(power_up_timer_enable_n_n),
    .brownout_mode_select(mode), .osc_crystal(xtal), .two_speed_en(two_speed),
    .fail_safe_en(fail_safe), .por_active(por), .vdd_above_bod(vdd_ok),
    .bod_trip(bod_trip), .external_reset_pin_n(pin_n), .osc_tick(osc_tick),
    .wdt_reset(wdt_rst), .wdt_wake(wdt_wk), .irq_wake(irq_wk), .sleep_entry(slp),
    .wdt_clear(wdt_clr), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .chip_reset(chip_reset), .internal_oscillator_exec(internal_oscillator_exec), .ost_running(ost_running),
    .bod_enable(bod_enable), .reset_pin_oe(reset_pin_oe));
  supply_clock_model u_far (.clk(clk), .rst(rst), .dip(dip), .osc_tick(osc_tick),
    .vdd_above_bod(vdd_ok), .bod_trip(bod_trip));

  // clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic range_ok(input int v, input int l, input int h);
    check({31'h0, (v >= l && v <= h)}, 32'h1);
  endtask
  // one avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) err_total++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // cycles until the core is let go, bounded so a stuck reset cannot hang
  task automatic wait_run();
    n = 0;
    seen_ost = 1'b0;
    seen_int = 1'b0;
    while (chip_reset !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
      if (ost_running === 1'b1) seen_ost = 1'b1;
      if (internal_oscillator_exec === 1'b1) seen_int = 1'b1;
    end
  endtask
  task automatic power_up();
    @(posedge clk);
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    wait_run();
  endtask
  task automatic sag(input int c);
    @(posedge clk);
    dip <= 1'b1;
    repeat (c) @(posedge clk);
    dip <= 1'b0;
  endtask
  // 0 watchdog reset, 1 watchdog wake, 2 interrupt wake, 3 sleep, 4 watchdog clear
  task automatic pulse(input int s);
    @(posedge clk);
    wdt_rst <= (s == 0);
    wdt_wk <= (s == 1);
    irq_wk <= (s == 2);
    slp <= (s == 3);
    wdt_clr <= (s == 4);
    @(posedge clk);
    {wdt_rst, wdt_wk, irq_wk, slp, wdt_clr} <= 5'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the reset pin stays an input whatever resets the core
  always @(posedge clk) begin
    if (!rst && reset_pin_oe !== 1'b0) begin
      $display("mismatch at %0t got %h expected %h", $time, reset_pin_oe, 1'b0);
      err_total++;
    end
  end

  // hang guard, far above the several hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    $display("watchdog expired");
    err_total++;
    print_verdict();
  end

  initial begin
    // supply good comes from the far-side model only
    {rst, por, pin_n} = 3'h7;
    {power_up_timer_enable_n_n, xtal, two_speed, fail_safe, dip, read, write} = 7'h00;
    {wdt_rst, wdt_wk, irq_wk, slp, wdt_clr} = 5'h00;
    mode = BOD_ALWAYS;
    address = 10'h000;
    writedata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    wait_run();
    range_ok(n, DLY, DLY + 6);
    bus(1'b0, A_ST, 32'h0);
    check(q, 32'h18);
    bus(1'b0, A_PC, 32'h0);
    check(q, 32'h11);
    bus(1'b1, A_PC, 32'hFFFFFFFF);
    bus(1'b0, A_PC, 32'h0);
    check(q, 32'h33);
    bus(1'b1, 10'h010, 32'hFFFFFFFF);
    bus(1'b0, 10'h010, 32'h0);
    check(q, 32'h0);
    end_test("registers");
    // plain, crystal, two-speed, delay off without and with crystal, fail-safe
    for (m = 0; m < 6; m++) begin
      xtal <= (m == 1 || m == 2 || m >= 4);
      two_speed <= (m == 2);
      fail_safe <= (m == 5);
      power_up_timer_enable_n_n <= (m == 3 || m == 4);
      power_up();
      range_ok(n, lo[m], hi[m]);
      check({31'h0, seen_ost}, {31'h0, xtal});
      check({31'h0, seen_int}, {31'h0, (m == 2 || m == 5)});
    end
    // the last fast start leaves its wait running; let it end before config moves
    repeat (2 * OSTC + 4) @(posedge clk);
    {xtal, two_speed, fail_safe, power_up_timer_enable_n_n} <= 4'h0;
    bus(1'b0, A_PC, 32'h0);
    check(q & 32'h3, 32'h1);
    bus(1'b1, A_PC, 32'h33);
    end_test("time-outs");
    sag(6);
    check({31'h0, chip_reset}, 32'h1);
    wait_run();
    range_ok(n, DLY, DLY + 8);
    bus(1'b0, A_PC, 32'h0);
    check(q & 32'h3, 32'h2);
    bus(1'b0, A_ST, 32'h0);
    check(q & 32'h18, 32'h18);
    sag(6);
    repeat (DLY / 2) @(posedge clk);
    sag(6);
    wait_run();
    range_ok(n, DLY, DLY + 8);
    end_test("brown-out");
    for (m = 0; m < 4; m++) begin
      mode <= bod_mode_t'(m);
      repeat (3) @(posedge clk);
      check({31'h0, bod_enable}, {31'h0, (m != 0)});
    end
    bus(1'b1, A_PC, 32'h23);
    for (m = 0; m < 2; m++) begin
      mode <= bod_mode_t'(m);
      sag(6);
      repeat (2) @(posedge clk);
      check({30'h0, bod_enable, chip_reset}, 32'h0);
    end
    mode <= BOD_SLEEP_GATED;
    pulse(3);
    check({31'h0, bod_enable}, 32'h0);
    bus(1'b1, A_PC, 32'h33);
    check({31'h0, bod_enable}, 32'h0);
    pulse(2);
    check({31'h0, bod_enable}, 32'h1);
    mode <= BOD_ALWAYS;
    pulse(3);
    check({31'h0, bod_enable}, 32'h1);
    pulse(2);
    end_test("detector modes");
    pulse(4);
    pulse(0);
    wait_run();
    range_ok(n, 0, 4);
    bus(1'b0, A_ST, 32'h0);
    check(q & 32'h18, 32'h08);
    pulse(3);
    pulse(1);
    bus(1'b0, A_ST, 32'h0);
    check(q & 32'h18, 32'h00);
    pulse(4);
    pulse(3);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    wait_run();
    bus(1'b0, A_ST, 32'h0);
    check(q & 32'h18, 32'h10);
    check({31'h0, reset_pin_oe}, 32'h0);
    end_test("cause flags");
    @(posedge clk);
    pin_n <= 1'b0;
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    repeat (DLY + 10) @(posedge clk);
    check({31'h0, chip_reset}, 32'h1);
    pin_n <= 1'b1;
    wait_run();
    range_ok(n, 0, 3);
    end_test("pin held low");
    print_verdict();
  end
endmodule // reset_timeout_sequencer_test
